// *** logic/htc_cfg.svh ***
`ifndef HTC_CFG_SVH
`define HTC_CFG_SVH

// register byte offsets
`define HTC_OFS_CTRL      12'h000
`define HTC_OFS_CHAN      12'h004
`define HTC_OFS_STATUS    12'h008
`define HTC_OFS_CMD       12'h00c
`define HTC_OFS_KEYA0     12'h010
`define HTC_OFS_KEYB0     12'h020
`define HTC_OFS_FREQ      12'h030

// control fields
`define HTC_CTRL_INVERT   0
`define HTC_CTRL_PROTO    1
`define HTC_CTRL_RATE     2
`define HTC_CTRL_KEYSEL   3

// command fields (write one)
`define HTC_CMD_COMMISSION 0
`define HTC_CMD_FACTORY    1
`define HTC_CMD_DECOMM     2

// channel numbering
`define HTC_CH_ADV0       7'd37
`define HTC_CH_ADV1       7'd38
`define HTC_CH_ADV2       7'd39
`define HTC_CH_SPLIT      7'd11
`define HTC_CH_CUSTOM0    7'd40
`define HTC_CH_MAX        7'd78
`define HTC_FREQ_BASE     12'd2400
`define HTC_FREQ_ADV0     12'd2402
`define HTC_FREQ_ADV1     12'd2426
`define HTC_FREQ_ADV2     12'd2480
`define HTC_FREQ_DATA0    12'd2404
`define HTC_FREQ_DATA11   12'd2428
`define HTC_FREQ_CUSTOM0  12'd2403

// reset values
`define HTC_CTRL_RST      4'h0
// pin idle levels: learn, contact 2, contact 1, supply b, supply a
`define HTC_PIN_IDLE      5'h1c
// arbitrary factory key value
`define HTC_FACTORY_KEY   128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
`define HTC_LFSR_SEED     32'h1ace_b00c

`endif

// *** logic/htc_pkg.sv ***
package htc_pkg;
	typedef enum logic [1:0] {
		HTC_TG_NONE,
		HTC_TG_DATA,
		HTC_TG_COMMISSION
	} htc_telegram_t;
endpackage

// *** logic/htc_trigger_control.sv ***
`timescale 1ns/1ps
`include "htc_cfg.svh"

// Summary of operation
// - supply b above supply a is press; below is release
// - invert option swaps press and release in data telegrams
// - data telegrams carry both contacts, low means active
// - learn held or pending request gives commissioning telegram
// - learn held: commissioning only in first actuation's direction
// - learn held: opposite direction sends nothing
// - pending request yields one commissioning telegram, then clears
// - no learn and no request: every actuation sends data
// - advertising protocol default; green power when selected
// - bit rate 1 Mbit/s default; 2 Mbit/s selectable
// - default channels 37, 38, 39; others configurable
// - advertising and data channels map to even MHz
// - custom channels 40..78 map to odd MHz from 2403
// - standard channels seed whitening with channel number
// - custom channels seed whitening with frequency minus 2400
// - factory key readable, writable, restored on factory reset
// - user key write only; random on factory reset, or on decommission with green power selected
// - key select chooses key; factory key by default
module htc_trigger_control (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    harvest_supply_a,
	input  wire logic                    harvest_supply_b,
	input  wire logic                    contact_in_first_n,
	input  wire logic                    contact_in_second_n,
	input  wire logic                    learn_button_n,
	output logic                         tx_start,
	output htc_pkg::htc_telegram_t       tx_kind,
	output logic                         tx_press,
	output logic      [1:0]              tx_contacts,
	output logic                         green_power_protocol,
	output logic                         rate_2mbit,
	output logic      [6:0]              tx_channel0,
	output logic      [6:0]              tx_channel1,
	output logic      [6:0]              tx_channel2,
	output logic      [6:0]              whiten_seed0,
	output logic      [6:0]              whiten_seed1,
	output logic      [6:0]              whiten_seed2,
	output logic      [127:0]            active_key
);

	// pin synchronisers, three stages each
	localparam int NPIN = 5;
	// start at idle levels: no false learn or contact right after reset
	localparam logic [NPIN-1:0] PIN_IDLE = `HTC_PIN_IDLE;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
	assign pin_raw = {learn_button_n, contact_in_second_n,
		contact_in_first_n, harvest_supply_b, harvest_supply_a};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_q[gi]  <= PIN_IDLE[gi];
					s2_q[gi]  <= PIN_IDLE[gi];
					s3_q[gi]  <= PIN_IDLE[gi];
					pin_q[gi] <= PIN_IDLE[gi];
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					// change counts only when stages two and three agree
					if (s2_q[gi] == s3_q[gi])
						pin_q[gi] <= s3_q[gi];
				end
			end
		end
	endgenerate

	logic sup_a, sup_b, learn_held;
	assign sup_a      = pin_q[0];
	assign sup_b      = pin_q[1];
	assign learn_held = !pin_q[4];

	logic actuate, act_press, act_q;
	assign actuate   = sup_a ^ sup_b;
	assign act_press = sup_b;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			act_q <= 1'b0;
		else
			act_q <= actuate;
	end
	logic act_start;
	assign act_start = actuate && !act_q;

	// retained configuration; no power-up clear beyond presetn
	logic [3:0]   ctrl_q;
	logic [6:0]   chan_q [3];
	logic [127:0] key_a_q, key_b_q;
	logic         req_q;
	logic         learn_dir_valid_q;
	logic         learn_dir_q;
	logic [31:0]  lfsr_q;

	// apb: zero wait states, unmapped reads zero with slverr
	logic wr_en, rd_en;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !pwrite;
	assign pready  = 1'b1;

	logic        hit_key_a, hit_key_b, mapped;
	logic [1:0]  key_word;
	assign key_word  = paddr[3:2];
	assign hit_key_a = (paddr[11:4] == 8'(`HTC_OFS_KEYA0 >> 4));
	assign hit_key_b = (paddr[11:4] == 8'(`HTC_OFS_KEYB0 >> 4));
	assign mapped = hit_key_a || hit_key_b ||
		paddr == `HTC_OFS_CTRL || paddr == `HTC_OFS_CHAN ||
		paddr == `HTC_OFS_STATUS || paddr == `HTC_OFS_CMD ||
		paddr == `HTC_OFS_FREQ;
	// user key reads back as an error; status and freq are read only
	assign pslverr = psel && penable && (!mapped ||
		(hit_key_b && !pwrite) ||
		(pwrite && (paddr == `HTC_OFS_STATUS ||
		paddr == `HTC_OFS_FREQ)));

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (st[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction

	logic wr_ok;
	assign wr_ok = wr_en && !pslverr;
	logic cmd_wr;
	assign cmd_wr = wr_ok && paddr == `HTC_OFS_CMD && pstrb[0];
	logic factory_rst, decomm;
	assign factory_rst = cmd_wr && pwdata[`HTC_CMD_FACTORY];
	assign decomm      = cmd_wr && pwdata[`HTC_CMD_DECOMM];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_q <= `HTC_CTRL_RST;
		else if (factory_rst)
			ctrl_q <= `HTC_CTRL_RST;
		else if (wr_ok && paddr == `HTC_OFS_CTRL && pstrb[0])
			ctrl_q <= pwdata[3:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_q[0] <= `HTC_CH_ADV0;
			chan_q[1] <= `HTC_CH_ADV1;
			chan_q[2] <= `HTC_CH_ADV2;
		end else if (factory_rst) begin
			chan_q[0] <= `HTC_CH_ADV0;
			chan_q[1] <= `HTC_CH_ADV1;
			chan_q[2] <= `HTC_CH_ADV2;
		end else if (wr_ok && paddr == `HTC_OFS_CHAN) begin
			for (int c = 0; c < 3; c++)
				if (pstrb[c] && pwdata[c*8 +: 7] <= `HTC_CH_MAX)
					chan_q[c] <= pwdata[c*8 +: 7];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			key_a_q <= `HTC_FACTORY_KEY;
		else if (factory_rst)
			key_a_q <= `HTC_FACTORY_KEY;
		else if (wr_ok && hit_key_a)
			key_a_q[key_word*32 +: 32] <=
				merge(key_a_q[key_word*32 +: 32], pwdata, pstrb);
	end

	// free-running lfsr as the fresh key source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lfsr_q <= `HTC_LFSR_SEED;
		else
			lfsr_q <= {lfsr_q[30:0],
				lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			key_b_q <= '0;
		else if (factory_rst || (decomm && ctrl_q[`HTC_CTRL_PROTO]))
			key_b_q <= {lfsr_q, ~lfsr_q, {lfsr_q[15:0], lfsr_q[31:16]},
				lfsr_q ^ 32'h5a5a_a5a5};
		else if (wr_ok && hit_key_b)
			key_b_q[key_word*32 +: 32] <=
				merge(key_b_q[key_word*32 +: 32], pwdata, pstrb);
	end

	// telegram decision
	logic send_comm, send_data, learn_match;
	assign learn_match = !learn_dir_valid_q || learn_dir_q == act_press;
	always_comb begin
		send_comm = 1'b0;
		send_data = 1'b0;
		if (act_start) begin
			if (learn_held)
				send_comm = learn_match;
			else if (req_q)
				send_comm = 1'b1;
			else
				send_data = 1'b1;
		end
	end

	// request latch, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			req_q <= 1'b0;
		else if (cmd_wr && pwdata[`HTC_CMD_COMMISSION])
			req_q <= 1'b1;
		else if (factory_rst || (act_start && !learn_held))
			req_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			learn_dir_valid_q <= 1'b0;
			learn_dir_q       <= 1'b0;
		end else if (!learn_held) begin
			learn_dir_valid_q <= 1'b0;
		end else if (act_start && !learn_dir_valid_q) begin
			learn_dir_valid_q <= 1'b1;
			learn_dir_q       <= act_press;
		end
	end

	// telegram outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_start    <= 1'b0;
			tx_kind     <= htc_pkg::HTC_TG_NONE;
			tx_press    <= 1'b0;
			tx_contacts <= 2'b00;
		end else begin
			tx_start <= send_comm || send_data;
			if (send_comm || send_data) begin
				tx_kind <= send_comm ? htc_pkg::HTC_TG_COMMISSION
					: htc_pkg::HTC_TG_DATA;
				tx_press <= act_press ^ ctrl_q[`HTC_CTRL_INVERT];
				tx_contacts <= ~pin_q[3:2];
			end
		end
	end

	assign green_power_protocol = ctrl_q[`HTC_CTRL_PROTO];
	assign rate_2mbit           = ctrl_q[`HTC_CTRL_RATE];
	assign active_key = ctrl_q[`HTC_CTRL_KEYSEL] ? key_b_q : key_a_q;
	assign tx_channel0 = chan_q[0];
	assign tx_channel1 = chan_q[1];
	assign tx_channel2 = chan_q[2];

	function automatic logic [11:0] ch_freq(input logic [6:0] ch);
		if (ch == `HTC_CH_ADV0)
			return `HTC_FREQ_ADV0;
		if (ch == `HTC_CH_ADV1)
			return `HTC_FREQ_ADV1;
		if (ch == `HTC_CH_ADV2)
			return `HTC_FREQ_ADV2;
		if (ch >= `HTC_CH_CUSTOM0)
			return `HTC_FREQ_CUSTOM0 +
				{4'h0, 7'(ch - `HTC_CH_CUSTOM0), 1'b0};
		if (ch < `HTC_CH_SPLIT)
			return `HTC_FREQ_DATA0 + {4'h0, ch, 1'b0};
		return `HTC_FREQ_DATA11 + {4'h0, 7'(ch - `HTC_CH_SPLIT), 1'b0};
	endfunction

	function automatic logic [6:0] seed(input logic [6:0] ch);
		logic [11:0] d;
		d = ch_freq(ch) - `HTC_FREQ_BASE;
		return (ch >= `HTC_CH_CUSTOM0) ? d[6:0] : ch;
	endfunction

	assign whiten_seed0 = seed(chan_q[0]);
	assign whiten_seed1 = seed(chan_q[1]);
	assign whiten_seed2 = seed(chan_q[2]);

	// read mux
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			if (hit_key_a)
				prdata = key_a_q[key_word*32 +: 32];
			else if (paddr == `HTC_OFS_CTRL)
				prdata = {28'h0, ctrl_q};
			else if (paddr == `HTC_OFS_CHAN)
				prdata = {9'h0, chan_q[2], 1'b0, chan_q[1],
					1'b0, chan_q[0]};
			else if (paddr == `HTC_OFS_STATUS)
				prdata = {26'h0, learn_dir_q, learn_dir_valid_q,
					~pin_q[3:2], learn_held, req_q};
			else if (paddr == `HTC_OFS_FREQ)
				prdata = {20'h0, ch_freq(chan_q[0])};
		end
	end

	// assertions
	a_comm_on_request:
	assert property (@(posedge pclk) disable iff (!presetn)
		act_start && req_q && !learn_held |=> tx_start &&
		tx_kind == htc_pkg::HTC_TG_COMMISSION && !req_q)
		else $error("pending request did not yield commissioning");

	a_data_when_idle:
	assert property (@(posedge pclk) disable iff (!presetn)
		act_start && !req_q && !learn_held |=> tx_start &&
		tx_kind == htc_pkg::HTC_TG_DATA)
		else $error("idle actuation did not yield data telegram");

	a_learn_opposite:
	assert property (@(posedge pclk) disable iff (!presetn)
		act_start && learn_held && learn_dir_valid_q &&
		learn_dir_q != act_press |=> !tx_start)
		else $error("opposite direction sent a telegram");

	a_learn_same:
	assert property (@(posedge pclk) disable iff (!presetn)
		act_start && learn_held && learn_dir_valid_q &&
		learn_dir_q == act_press |=> tx_start &&
		tx_kind == htc_pkg::HTC_TG_COMMISSION)
		else $error("learn direction missed commissioning");

	a_press_encode:
	assert property (@(posedge pclk) disable iff (!presetn)
		send_data |=> tx_press ==
		($past(sup_b) ^ $past(ctrl_q[`HTC_CTRL_INVERT])))
		else $error("press encoding wrong");

	a_contact_level:
	assert property (@(posedge pclk) disable iff (!presetn)
		send_data |=> tx_contacts == ~$past(pin_q[3:2]))
		else $error("contact states wrong");

	a_custom_seed:
	assert property (@(posedge pclk) disable iff (!presetn)
		chan_q[0] >= `HTC_CH_CUSTOM0 |->
		whiten_seed0 == 7'(2 * chan_q[0] - 7'd77))
		else $error("custom seed wrong");

	a_factory_key:
	assert property (@(posedge pclk) disable iff (!presetn)
		factory_rst |=> key_a_q == `HTC_FACTORY_KEY && ctrl_q == 4'h0)
		else $error("factory reset did not restore");

	a_user_key_hidden:
	assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite && hit_key_b |-> pslverr &&
		prdata == 32'h0000_0000)
		else $error("user key readable");

endmodule // htc_trigger_control

// *** sim/htc_harvester_model.sv ***
`timescale 1ns/1ps
module htc_harvester_model (
	input  wire logic pclk,
	output logic      harvest_supply_a,
	output logic      harvest_supply_b,
	output logic      contact_in_first_n,
	output logic      contact_in_second_n,
	output logic      learn_button_n
);
	// idle: no supply difference, contacts open, learn released
	initial begin
		harvest_supply_a = 1'b0;
		harvest_supply_b = 1'b0;
		contact_in_first_n = 1'b1;
		contact_in_second_n = 1'b1;
		learn_button_n = 1'b1;
	end

	// grounded or open
	// contacts and learn only move between actuations
	task set_pins(input logic [1:0] act, input logic learn);
		@(posedge pclk);
		contact_in_first_n <= ~act[0];
		contact_in_second_n <= ~act[1];
		learn_button_n <= ~learn;
	endtask

	// supply polarity
	// press: terminal b above a; release: a above b
	task actuate(input logic press);
		@(posedge pclk);
		harvest_supply_b <= press;
		harvest_supply_a <= ~press;
		repeat (12) @(posedge pclk);
		harvest_supply_b <= 1'b0;
		harvest_supply_a <= 1'b0;
		// energy gone: pins settle equal before the next action
		repeat (12) @(posedge pclk);
	endtask
endmodule // htc_harvester_model

// *** sim/harvester_telegram_trigger_control_bench.sv ***
`timescale 1ns/1ps
`include "htc_cfg.svh"
module harvester_telegram_trigger_control_bench;
	logic                   pclk, presetn, psel, penable, pwrite;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata, rdat;
	logic [3:0]             pstrb;
	logic                   pready, pslverr, sa, sb, c1n, c2n, lrn_n;
	logic                   tx_start, tx_press, green_power_protocol;
	logic                   rate_2mbit;
	htc_pkg::htc_telegram_t tx_kind;
	logic [1:0]             tx_contacts;
	logic [6:0]             ch0, ch1, ch2, ws0, ws1, ws2;
	logic [127:0]           active_key, old_key;
	int                     num_errors = 0, num_checks = 0;
	int                     n_tx = 0, cycles = 0;
	int                     ch[6] = '{37, 0, 11, 39, 40, 78};
	int                     fq[6] = '{2402, 2404, 2428, 2480, 2403, 2479};

	htc_trigger_control htc_trigger_control_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.harvest_supply_a(sa), .harvest_supply_b(sb),
		.contact_in_first_n(c1n), .contact_in_second_n(c2n),
		.learn_button_n(lrn_n), .tx_start(tx_start), .tx_kind(tx_kind),
		.tx_press(tx_press), .tx_contacts(tx_contacts),
		.green_power_protocol(green_power_protocol),
		.rate_2mbit(rate_2mbit), .tx_channel0(ch0), .tx_channel1(ch1),
		.tx_channel2(ch2), .whiten_seed0(ws0), .whiten_seed1(ws1),
		.whiten_seed2(ws2), .active_key(active_key));

	htc_harvester_model htc_harvester_model_inst (
		.pclk(pclk), .harvest_supply_a(sa), .harvest_supply_b(sb),
		.contact_in_first_n(c1n), .contact_in_second_n(c2n),
		.learn_button_n(lrn_n));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (tx_start === 1'b1)
			n_tx <= n_tx + 1;
		cycles <= cycles + 1;
		// a few hundred cycles expected; far above means a hang
		if (cycles == 5000) begin
			num_errors++;
			stop_test();
		end
	end

	task stop_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		num_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
			num_errors++;
		end
	endtask

	// entered just after a rising edge; zero or more wait states
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic xe);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		chk("pready", 1'b1, pready);
		chk("pslverr", xe, pslverr);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// one actuation; press and contacts only mean something in data
	task act(input logic pr, input htc_pkg::htc_telegram_t k,
		input logic p, input logic [1:0] c);
		int n0;
		n0 = n_tx;
		htc_harvester_model_inst.actuate(pr);
		if (k == htc_pkg::HTC_TG_NONE)
			chk("telegrams", n0, n_tx);
		else begin
			chk("telegrams", n0 + 1, n_tx);
			chk("kind", k, tx_kind);
		end
		if (k == htc_pkg::HTC_TG_DATA) begin
			chk("press", p, tx_press);
			chk("contacts", c, tx_contacts);
		end
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("channels", {7'd37, 7'd38, 7'd39}, {ch0, ch1, ch2});
		chk("seeds", {7'd37, 7'd38, 7'd39}, {ws0, ws1, ws2});
		chk("protocol", 1'b0, green_power_protocol);
		chk("rate", 1'b0, rate_2mbit);
		chk("key", `HTC_FACTORY_KEY, active_key);
		htc_harvester_model_inst.set_pins(2'b01, 1'b0);
		act(1'b1, htc_pkg::HTC_TG_DATA, 1'b1, 2'b01);
		htc_harvester_model_inst.set_pins(2'b10, 1'b0);
		act(1'b0, htc_pkg::HTC_TG_DATA, 1'b0, 2'b10);
		apb(1'b1, `HTC_OFS_CTRL, 32'h1, 1'b0);
		act(1'b1, htc_pkg::HTC_TG_DATA, 1'b0, 2'b10);
		act(1'b0, htc_pkg::HTC_TG_DATA, 1'b1, 2'b10);
		apb(1'b1, `HTC_OFS_CTRL, 32'h0, 1'b0);
		apb(1'b1, `HTC_OFS_CMD, 32'h1, 1'b0);
		act(1'b0, htc_pkg::HTC_TG_COMMISSION, 1'b0, 2'b10);
		act(1'b1, htc_pkg::HTC_TG_DATA, 1'b1, 2'b10);
		htc_harvester_model_inst.set_pins(2'b11, 1'b1);
		act(1'b0, htc_pkg::HTC_TG_COMMISSION, 1'b0, 2'b11);
		act(1'b1, htc_pkg::HTC_TG_NONE, 1'b0, 2'b11);
		act(1'b0, htc_pkg::HTC_TG_COMMISSION, 1'b0, 2'b11);
		htc_harvester_model_inst.set_pins(2'b00, 1'b0);
		act(1'b1, htc_pkg::HTC_TG_DATA, 1'b1, 2'b00);
		apb(1'b1, `HTC_OFS_CTRL, 32'h6, 1'b0);
		chk("protocol", 1'b1, green_power_protocol);
		chk("rate", 1'b1, rate_2mbit);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, `HTC_OFS_CHAN, {8'd0, 8'd39, 8'd38, 8'(ch[i])}, 1'b0);
			chk("channel0", ch[i], ch0);
			apb(1'b0, `HTC_OFS_FREQ, 32'h0, 1'b0);
			chk("freq", fq[i], rdat);
			chk("seed0", (ch[i] >= 40) ? fq[i] - 2400 : ch[i], ws0);
		end
		// channel 79 lies past the custom range and is dropped
		apb(1'b1, `HTC_OFS_CHAN, {8'd0, 8'd39, 8'd38, 8'd79}, 1'b0);
		chk("channel0", 7'd78, ch0);
		apb(1'b1, `HTC_OFS_KEYA0, 32'h1234_5678, 1'b0);
		apb(1'b0, `HTC_OFS_KEYA0, 32'h0, 1'b0);
		chk("key_a", 32'h1234_5678, rdat);
		apb(1'b0, `HTC_OFS_KEYB0, 32'h0, 1'b1);
		apb(1'b1, `HTC_OFS_KEYB0, 32'h0bad_cafe, 1'b0);
		apb(1'b1, `HTC_OFS_CTRL, 32'h8, 1'b0);
		chk("key", {96'h0, 32'h0bad_cafe}, active_key);
		apb(1'b1, `HTC_OFS_CMD, 32'h2, 1'b0);
		chk("key", `HTC_FACTORY_KEY, active_key);
		apb(1'b0, `HTC_OFS_CTRL, 32'h0, 1'b0);
		chk("ctrl", 32'h0, rdat);
		apb(1'b1, `HTC_OFS_CTRL, 32'h8, 1'b0);
		old_key = active_key;
		chk("key_b_fresh", 1'b0, old_key === {96'h0, 32'h0bad_cafe});
		apb(1'b1, `HTC_OFS_CMD, 32'h4, 1'b0);
		chk("key_b_kept", old_key, active_key);
		apb(1'b1, `HTC_OFS_CTRL, 32'ha, 1'b0);
		apb(1'b1, `HTC_OFS_CMD, 32'h4, 1'b0);
		chk("key_b_new", 1'b0, old_key === active_key);
		apb(1'b0, 12'h040, 32'h0, 1'b1);
		apb(1'b1, `HTC_OFS_STATUS, 32'h1, 1'b1);
		stop_test();
	end
endmodule // harvester_telegram_trigger_control_bench
